//--- logic/itsq_top.sv
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`include "itsq_map.svh"
module itsq_top
    import itsq_pkg::*;
#(
    parameter int unsigned NUM_SRC = 8,
    parameter int unsigned ROWS    = 16,
    parameter int unsigned SEC_US  = `ITSQ_SEC_US,
    parameter int unsigned US_CYC  = `ITSQ_US_CYC
) (
    input  wire logic               clk_i,
    input  wire logic               arst_n_i,
    input  wire logic               ce_i,
    input  wire logic               hsel_i,
    input  wire logic [31:0]        haddr_i,
    input  wire logic [1:0]         htrans_i,
    input  wire logic               hwrite_i,
    input  wire logic [2:0]         hsize_i,
    input  wire logic [31:0]        hwdata_i,
    input  wire logic               hready_i,
    input  wire logic [NUM_SRC-1:0] trig_src_i,
    input  wire logic               luma_high_i,
    input  wire logic               luma_low_i,
    output logic [31:0]             hrdata_o,
    output logic                    hreadyout_o,
    output logic                    hresp_o,
    output logic                    run_active_o,
    output logic                    exposing_o,
    output logic                    readout_o,
    output logic                    row_strobe_o,
    output logic                    frame_begin_o
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // reset release through two flops
    logic [1:0] rst_sq;
    logic       rst_n;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) rst_sq <= 2'b00;
        else           rst_sq <= {rst_sq[0], 1'b1};
    end
    assign rst_n = rst_sq[1];

    // configuration and state
    itsq_mode_t  mode_q;
    itsq_ttype_t ttype_q;
    itsq_sense_t sense_q;
    itsq_auto_t  aex_q;
    itsq_state_t state_q;
    logic        expk_q, manr_q, ovl_q, bend_q, run_q, rd_busy_q, slot_q;
    logic [2:0]  ten_q;
    logic [3:0]  orig_q;
    logic [15:0] total_q, burst_q, credit_q;
    logic        unlim_q;
    logic [23:0] exp_q, dly_q, tmr_q;
    logic [31:0] frate_q, lrate_q, achv_q, frm_cnt_q, sec_cnt_q;
    logic [15:0] us_cnt_q, row_cnt_q;
    logic        src_prev_q;

    // ahb-lite slave: writes zero-wait, reads one wait state
    // the wait lets a read see a write finished the cycle before
    logic        ap_wr_q, ap_rd_q, hready_q, hresp_q;
    logic [7:0]  ap_addr_q;
    logic [31:0] hrdata_q;
    wire         bus_acc = hsel_i && htrans_i[1] && hready_i;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ap_wr_q   <= 1'b0;
            ap_rd_q   <= 1'b0;
            ap_addr_q <= 8'h00;
            hready_q  <= 1'b1;
            hresp_q   <= 1'b0;
        end else if (ce_i) begin
            ap_wr_q   <= bus_acc && hwrite_i;
            ap_rd_q   <= bus_acc && !hwrite_i;
            ap_addr_q <= bus_acc ? haddr_i[7:0] : ap_addr_q;
            hready_q  <= !(bus_acc && !hwrite_i);
        end
    end

    // write strobes, valid in the data phase
    wire wr_cmd  = ap_wr_q && hit(ap_addr_q, `ITSQ_OFF_CMD);
    wire wr_rc   = ap_wr_q && hit(ap_addr_q, `ITSQ_OFF_RUNCFG);
    wire wr_tc   = ap_wr_q && hit(ap_addr_q, `ITSQ_OFF_TRIG);
    wire wr_exp  = ap_wr_q && hit(ap_addr_q, `ITSQ_OFF_EXPUS);
    wire cmd_beg = wr_cmd && hwdata_i[`ITSQ_CMD_BEGIN];
    wire cmd_end = wr_cmd && hwdata_i[`ITSQ_CMD_END];
    wire sw_trig = wr_cmd && hwdata_i[`ITSQ_CMD_SWTRIG] && orig_q == 4'h0;

    // read mux, unmapped offsets read zero
    logic [31:0] rd_mux;
    assign rd_mux =
        hit(ap_addr_q, `ITSQ_OFF_RUNCFG) ? {19'h0, manr_q, 2'h0, aex_q, 3'h0, expk_q, 2'h0, mode_q} :
        hit(ap_addr_q, `ITSQ_OFF_TOTAL)  ? {16'h0, total_q} :
        hit(ap_addr_q, `ITSQ_OFF_BURST)  ? {16'h0, burst_q} :
        hit(ap_addr_q, `ITSQ_OFF_TRIG)   ? {11'h0, bend_q, 1'b0, ten_q, 3'h0, ovl_q, 1'b0,
                                            sense_q, orig_q, 2'h0, ttype_q} :
        hit(ap_addr_q, `ITSQ_OFF_EXPUS)  ? {8'h0, exp_q} :
        hit(ap_addr_q, `ITSQ_OFF_DLYUS)  ? {8'h0, dly_q} :
        hit(ap_addr_q, `ITSQ_OFF_FRATE)  ? frate_q :
        hit(ap_addr_q, `ITSQ_OFF_LRATE)  ? lrate_q :
        hit(ap_addr_q, `ITSQ_OFF_ACHV)   ? achv_q :
        hit(ap_addr_q, `ITSQ_OFF_STAT)   ? {credit_q, 9'h0, unlim_q, rd_busy_q, run_q, state_q} :
        32'h0000_0000;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)                 hrdata_q <= 32'h0000_0000;
        else if (ce_i && ap_rd_q)   hrdata_q <= rd_mux;
    end

    // host-written settings; auto-once clear loses to a host write
    wire exp_end;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mode_q  <= ITSQ_CONT;
            expk_q  <= 1'b0;
            aex_q   <= ITSQ_AE_CONT;
            manr_q  <= 1'b0;
            total_q <= `ITSQ_RST_TOTAL;
            burst_q <= `ITSQ_RST_BURST;
            dly_q   <= 24'h000000;
            frate_q <= `ITSQ_RST_FRATE;
            lrate_q <= `ITSQ_RST_LRATE;
        end else if (ce_i) begin
            if (wr_rc) begin
                mode_q <= itsq_mode_t'(hwdata_i[`ITSQ_RC_MODE]);
                expk_q <= hwdata_i[`ITSQ_RC_EXPK];
                aex_q  <= itsq_auto_t'(hwdata_i[`ITSQ_RC_AUTO]);
                manr_q <= hwdata_i[`ITSQ_RC_MANR];
            end else if (exp_end && aex_q == ITSQ_AE_ONCE) begin
                aex_q  <= ITSQ_AE_OFF;
            end
            if (ap_wr_q && hit(ap_addr_q, `ITSQ_OFF_TOTAL)) total_q <= hwdata_i[15:0];
            if (ap_wr_q && hit(ap_addr_q, `ITSQ_OFF_BURST)) burst_q <= hwdata_i[15:0];
            if (ap_wr_q && hit(ap_addr_q, `ITSQ_OFF_DLYUS)) dly_q   <= hwdata_i[23:0];
            if (ap_wr_q && hit(ap_addr_q, `ITSQ_OFF_FRATE)) frate_q <= hwdata_i;
            if (ap_wr_q && hit(ap_addr_q, `ITSQ_OFF_LRATE)) lrate_q <= hwdata_i;
        end
    end

    // trigger settings, all enables off after reset
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ttype_q <= ITSQ_T_START;
            orig_q  <= 4'h0;
            sense_q <= ITSQ_RISE;
            ovl_q   <= 1'b0;
            ten_q   <= 3'h0;
            bend_q  <= 1'b0;
        end else if (ce_i && wr_tc) begin
            ttype_q <= itsq_ttype_t'(hwdata_i[`ITSQ_TC_TYPE]);
            orig_q  <= hwdata_i[`ITSQ_TC_ORIG];
            sense_q <= itsq_sense_t'(hwdata_i[`ITSQ_TC_SENSE]);
            ovl_q   <= hwdata_i[`ITSQ_TC_OVL];
            ten_q   <= hwdata_i[`ITSQ_TC_EN];
            bend_q  <= hwdata_i[`ITSQ_TC_BEND];
        end
    end

    // microsecond tick
    wire us_tick = us_cnt_q == 16'(US_CYC - 1);
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)    us_cnt_q <= 16'h0000;
        else if (ce_i) us_cnt_q <= us_tick ? 16'h0000 : us_cnt_q + 16'h0001;
    end

    // rate generators: frame pacing and row pacing, phase-accumulated in hertz
    logic [1:0] nco_hit;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_nco
            logic [31:0] acc_q;
            wire  [31:0] rate = (g == 0) ? frate_q : lrate_q;
            wire  [32:0] sum  = {1'b0, acc_q} + {1'b0, rate};
            assign nco_hit[g] = us_tick && sum >= 33'(SEC_US);
            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n)               acc_q <= 32'h0000_0000;
                else if (ce_i && us_tick) acc_q <= nco_hit[g] ? 32'(sum - 33'(SEC_US)) : sum[31:0];
            end
        end
    endgenerate

    // trigger source and activation
    wire [NUM_SRC:0] src_vec = {trig_src_i, 1'b0};
    wire src_lvl = (orig_q != 4'h0 && 32'(orig_q) <= NUM_SRC) ? src_vec[orig_q] : 1'b0;
    wire hw_evt =
        (sense_q == ITSQ_LOW)  ? !src_lvl :
        (sense_q == ITSQ_HIGH) ? src_lvl :
        (sense_q == ITSQ_FALL) ? (src_prev_q && !src_lvl) :
        (sense_q == ITSQ_RISE) ? (!src_prev_q && src_lvl) :
        (sense_q == ITSQ_ANY)  ? (src_prev_q ^ src_lvl) : 1'b0;
    wire raw_trig = sw_trig || (orig_q != 4'h0 && hw_evt);
    wire act_lvl  = (sense_q == ITSQ_LOW || sense_q == ITSQ_FALL) ? !src_lvl : src_lvl;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)    src_prev_q <= 1'b0;
        else if (ce_i) src_prev_q <= src_lvl;
    end

    // grant decisions
    wire gated    = ten_q[ttype_q];
    wire burst_en = ten_q[ITSQ_T_BURST] && !bend_q;
    wire have     = unlim_q || credit_q != 16'h0000;
    wire pace_ok  = !manr_q || slot_q;
    wire rd_free  = ovl_q || !rd_busy_q;
    wire accept   = raw_trig && run_q && gated && state_q == ITSQ_S_WAIT
                    && !have && rd_free;
    wire go       = state_q == ITSQ_S_WAIT && have && pace_ok && rd_free;
    wire dly_done = state_q == ITSQ_S_DELAY && tmr_q == 24'h000000;
    wire [15:0] mode_cnt = (mode_q == ITSQ_SINGLE)  ? 16'h0001 :
                           (mode_q == ITSQ_COUNTED) ? total_q : 16'h0000;
    wire cont     = mode_q != ITSQ_SINGLE && mode_q != ITSQ_COUNTED;
    wire [15:0] trig_cnt = !cont ? mode_cnt :
                           (ttype_q == ITSQ_T_FRAME) ? 16'h0001 :
                           (ttype_q == ITSQ_T_BURST && burst_en) ? burst_q : 16'h0001;
    wire keep_run = cont || (gated && ttype_q == ITSQ_T_BURST);
    assign exp_end = state_q == ITSQ_S_EXPOSE && !rd_busy_q &&
                     (expk_q ? !act_lvl : tmr_q == 24'h000000);
    wire last_img = !unlim_q && credit_q == 16'h0000;

    // run sequencer
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= ITSQ_S_IDLE;
            run_q    <= 1'b0;
            credit_q <= 16'h0000;
            unlim_q  <= 1'b0;
            tmr_q    <= 24'h000000;
        end else if (ce_i) begin
            if (cmd_end) begin
                state_q  <= ITSQ_S_IDLE;
                run_q    <= 1'b0;
                credit_q <= 16'h0000;
                unlim_q  <= 1'b0;
            end else if (cmd_beg) begin
                state_q  <= ITSQ_S_WAIT;
                run_q    <= 1'b1;
                credit_q <= gated ? 16'h0000 : mode_cnt;
                unlim_q  <= !gated && cont;
            end else begin
                unique case (state_q)
                    ITSQ_S_IDLE: ;
                    ITSQ_S_WAIT: begin
                        if (go) begin
                            state_q  <= ITSQ_S_EXPOSE;
                            tmr_q    <= (exp_q == 24'h000000) ? 24'h000001 : exp_q;
                            credit_q <= unlim_q ? credit_q : credit_q - 16'h0001;
                        end else if (accept) begin
                            state_q  <= ITSQ_S_DELAY;
                            tmr_q    <= dly_q;
                        end
                    end
                    ITSQ_S_DELAY: begin
                        if (dly_done) begin
                            state_q  <= ITSQ_S_WAIT;
                            credit_q <= trig_cnt;
                            unlim_q  <= cont && ttype_q == ITSQ_T_START;
                        end else if (us_tick) begin
                            tmr_q    <= tmr_q - 24'h000001;
                        end
                    end
                    ITSQ_S_EXPOSE: begin
                        if (exp_end) begin
                            state_q <= (last_img && !keep_run) ? ITSQ_S_IDLE : ITSQ_S_WAIT;
                            run_q   <= !(last_img && !keep_run);
                        end else if (us_tick && tmr_q != 24'h000000) begin
                            tmr_q   <= tmr_q - 24'h000001;
                        end
                    end
                endcase
            end
        end
    end

    // frame slot waits to be used; automatic rate runs back to back
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)    slot_q <= 1'b0;
        else if (ce_i) slot_q <= nco_hit[0] || (slot_q && !go);
    end

    // auto exposure nudges the duration by an eighth plus one us per frame
    wire [23:0] exp_step = (exp_q >> 3) + 24'h000001;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            exp_q <= `ITSQ_RST_EXPUS;
        end else if (ce_i) begin
            if (wr_exp)
                exp_q <= hwdata_i[23:0];
            else if (exp_end && aex_q != ITSQ_AE_OFF && luma_high_i && exp_q > exp_step)
                exp_q <= exp_q - exp_step;
            else if (exp_end && aex_q != ITSQ_AE_OFF && luma_low_i)
                exp_q <= exp_q + exp_step;
        end
    end

    // readout walks the rows at the line rate
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_busy_q <= 1'b0;
            row_cnt_q <= 16'h0000;
        end else if (ce_i) begin
            if (exp_end) begin
                rd_busy_q <= 1'b1;
                row_cnt_q <= 16'(ROWS);
            end else if (rd_busy_q && nco_hit[1]) begin
                row_cnt_q <= row_cnt_q - 16'h0001;
                rd_busy_q <= row_cnt_q != 16'h0001;
            end
        end
    end

    // achieved rate: frames begun per one-second window
    wire sec_wrap = us_tick && sec_cnt_q == SEC_US - 1;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt_q <= 32'h0000_0000;
            frm_cnt_q <= 32'h0000_0000;
            achv_q    <= 32'h0000_0000;
        end else if (ce_i) begin
            if (us_tick) sec_cnt_q <= sec_wrap ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
            if (sec_wrap) begin
                achv_q    <= frm_cnt_q + {31'h0, go};
                frm_cnt_q <= 32'h0000_0000;
            end else if (go) begin
                frm_cnt_q <= frm_cnt_q + 32'h0000_0001;
            end
        end
    end

    // registered pulse outputs
    logic frame_q, row_q;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            frame_q <= 1'b0;
            row_q   <= 1'b0;
        end else if (ce_i) begin
            frame_q <= go;
            row_q   <= rd_busy_q && nco_hit[1];
        end
    end

    assign hrdata_o      = hrdata_q;
    assign hreadyout_o   = hready_q;
    assign hresp_o       = hresp_q;
    assign run_active_o  = run_q;
    assign exposing_o    = state_q[3];
    assign readout_o     = rd_busy_q;
    assign row_strobe_o  = row_q;
    assign frame_begin_o = frame_q;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    AST_END_STOPS: assert property (ce_i && cmd_end |=> !run_q && state_q == ITSQ_S_IDLE)
        else $error("run did not stop after end command");
    AST_COUNTED_LOAD: assert property (ce_i && cmd_beg && !cmd_end && !gated
        && mode_q == ITSQ_COUNTED |=> credit_q == $past(total_q) && !unlim_q)
        else $error("counted run did not load total");
    AST_SINGLE_ONE: assert property (ce_i && go && mode_q == ITSQ_SINGLE && !cmd_beg
        && !cmd_end |=> credit_q == 16'h0000 && !unlim_q)
        else $error("single run left credit");
    AST_NO_STRAY: assert property (ce_i && state_q == ITSQ_S_WAIT && !cmd_beg && !cmd_end
        && (!gated || !run_q) |=> state_q != ITSQ_S_DELAY)
        else $error("delay entered without enabled trigger");
    AST_OVL_OFF: assert property (ce_i && !ovl_q && rd_busy_q && state_q == ITSQ_S_WAIT
        && !cmd_beg && !cmd_end |=> state_q == ITSQ_S_WAIT || state_q == ITSQ_S_IDLE)
        else $error("capture began during readout with overlap off");
    AST_SW_SRC: assert property (ce_i && wr_cmd && hwdata_i[`ITSQ_CMD_SWTRIG]
        && orig_q != 4'h0 && !hw_evt && state_q == ITSQ_S_WAIT && !cmd_beg && !cmd_end
        |=> state_q != ITSQ_S_DELAY)
        else $error("software trigger with hardware source");
    AST_DELAY_HOLD: assert property (ce_i && state_q == ITSQ_S_DELAY && tmr_q != 24'h000000
        && !cmd_beg && !cmd_end |=> state_q == ITSQ_S_DELAY)
        else $error("delay ended early");
    AST_FRAME_CONT: assert property (ce_i && dly_done && !cmd_beg && !cmd_end && cont
        && ttype_q == ITSQ_T_FRAME |=> credit_q == 16'h0001 && !unlim_q)
        else $error("per-frame trigger did not grant one image");
    AST_AUTO_ONCE: assert property (ce_i && exp_end && aex_q == ITSQ_AE_ONCE && !wr_rc
        |=> aex_q == ITSQ_AE_OFF)
        else $error("auto once did not return to off");
    AST_MANUAL_PACE: assert property (ce_i && manr_q && go |=> !slot_q || $past(nco_hit[0]))
        else $error("rate slot not used up by frame start");
    AST_FRAME_PULSE: assert property (ce_i && go |=> frame_begin_o)
        else $error("frame begin pulse missing");

    COV_COUNTED: cover property (go && mode_q == ITSQ_COUNTED ##[1:1000] !run_q);
    COV_DELAY: cover property (state_q == ITSQ_S_DELAY ##1 state_q == ITSQ_S_WAIT);
    COV_OVERLAP: cover property (rd_busy_q && state_q == ITSQ_S_EXPOSE);
    COV_ONCE: cover property (aex_q == ITSQ_AE_ONCE ##1 aex_q == ITSQ_AE_OFF);
endmodule

//--- logic/itsq_map.svh
`ifndef ITSQ_MAP_SVH
`define ITSQ_MAP_SVH
// timing
`define ITSQ_CLK_NS     5
`define ITSQ_US_NS      1000
`define ITSQ_US_CYC     (`ITSQ_US_NS / `ITSQ_CLK_NS)
`define ITSQ_SEC_US     1000000
// register byte offsets
`define ITSQ_OFF_CMD    8'h00
`define ITSQ_OFF_RUNCFG 8'h04
`define ITSQ_OFF_TOTAL  8'h08
`define ITSQ_OFF_BURST  8'h0C
`define ITSQ_OFF_TRIG   8'h10
`define ITSQ_OFF_EXPUS  8'h14
`define ITSQ_OFF_DLYUS  8'h18
`define ITSQ_OFF_FRATE  8'h1C
`define ITSQ_OFF_LRATE  8'h20
`define ITSQ_OFF_ACHV   8'h24
`define ITSQ_OFF_STAT   8'h28
// command bits
`define ITSQ_CMD_BEGIN  0
`define ITSQ_CMD_END    1
`define ITSQ_CMD_SWTRIG 2
// run config fields
`define ITSQ_RC_MODE    1:0
`define ITSQ_RC_EXPK    4
`define ITSQ_RC_AUTO    9:8
`define ITSQ_RC_MANR    12
// trigger config fields
`define ITSQ_TC_TYPE    1:0
`define ITSQ_TC_ORIG    7:4
`define ITSQ_TC_SENSE   10:8
`define ITSQ_TC_OVL     12
`define ITSQ_TC_EN      18:16
`define ITSQ_TC_BEND    20
// reset values
`define ITSQ_RST_TOTAL  16'h0001
`define ITSQ_RST_BURST  16'h0001
`define ITSQ_RST_EXPUS  24'h002710
`define ITSQ_RST_FRATE  32'h0000001E
`define ITSQ_RST_LRATE  32'h00004E20
`endif

//--- logic/itsq_pkg.sv
package itsq_pkg;
    typedef enum logic [1:0] {
        ITSQ_CONT    = 2'h0,
        ITSQ_COUNTED = 2'h1,
        ITSQ_SINGLE  = 2'h2
    } itsq_mode_t;
    typedef enum logic [1:0] {
        ITSQ_T_START = 2'h0,
        ITSQ_T_FRAME = 2'h1,
        ITSQ_T_BURST = 2'h2
    } itsq_ttype_t;
    typedef enum logic [2:0] {
        ITSQ_LOW  = 3'h0,
        ITSQ_HIGH = 3'h1,
        ITSQ_FALL = 3'h2,
        ITSQ_RISE = 3'h3,
        ITSQ_ANY  = 3'h4
    } itsq_sense_t;
    typedef enum logic [1:0] {
        ITSQ_AE_OFF  = 2'h0,
        ITSQ_AE_ONCE = 2'h1,
        ITSQ_AE_CONT = 2'h2
    } itsq_auto_t;
    typedef enum logic [3:0] {
        ITSQ_S_IDLE   = 4'b0001,
        ITSQ_S_WAIT   = 4'b0010,
        ITSQ_S_DELAY  = 4'b0100,
        ITSQ_S_EXPOSE = 4'b1000
    } itsq_state_t;
endpackage

//--- verification/itsq_line_model.sv
// external trigger lines: a fired line goes high for HOLD cycles
module itsq_line_model #(
    parameter int unsigned N    = 8,
    parameter int unsigned HOLD = 6
) (
    input  wire logic         clk_i,
    input  wire logic [N-1:0] fire_i,
    output logic [N-1:0]      line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cnt_q [N];
    // lines idle low, as with a pull-down, so no stale level lingers
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < N; i++) begin
            if (fire_i[i]) cnt_q[i] <= HOLD;
            else if (cnt_q[i] != 0) cnt_q[i] <= cnt_q[i] - 1;
        end
    end
    always_comb begin
        for (int i = 0; i < N; i++) line_o[i] = (cnt_q[i] != 0);
    end
endmodule

//--- verification/itsq_top_tb_top.sv
`include "itsq_map.svh"
module itsq_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic        hrdy, hresp, run, expo, rdo, rowp, fb;
    logic [7:0]  fire_q = 8'h00, lines;
    logic        ce = 1'b1, lh = 1'b0, ll = 1'b0;
    logic [2:0]  hsize = 3'h2;
    int          errors = 0, n_compared = 0, nfr = 0, mark = 0, cyc = 0, nrow = 0;
    // sim-sized timing: 4 cycles per us, 1000 us rate window
    itsq_top #(.NUM_SRC(8), .ROWS(4), .SEC_US(1000), .US_CYC(4)) dut_u (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hrdy), .trig_src_i(lines),
        .luma_high_i(lh), .luma_low_i(ll), .hrdata_o(hrdata),
        .hreadyout_o(hrdy), .hresp_o(hresp), .run_active_o(run),
        .exposing_o(expo), .readout_o(rdo), .row_strobe_o(rowp), .frame_begin_o(fb));
    itsq_line_model #(.N(8), .HOLD(6)) line_u (
        .clk_i(clk_i), .fire_i(fire_q), .line_o(lines));
    always #2.5 clk_i = ~clk_i;
    // frame counter and hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (fb === 1'b1) nfr++;
        if (rowp === 1'b1) nrow++;
        if (cyc == 40000) begin
            errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one whole-word transfer; held until hready is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(nm, e, r);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    // bounded wait for the run and its readout to finish
    task automatic wait_done();
        int k;
        k = 0;
        repeat (2) @(posedge clk_i);
        while ((run !== 1'b0 || rdo !== 1'b0) && k < 4000) begin
            @(posedge clk_i);
            k++;
        end
    endtask
    task automatic frames(input string nm, input int e);
        chk(nm, 32'(e), 32'(nfr - mark));
        mark = nfr;
    endtask
    task automatic fire();
        fire_q <= 8'h01;
        @(posedge clk_i);
        fire_q <= 8'h00;
    endtask
    task automatic t_reset();
        rd("runcfg", `ITSQ_OFF_RUNCFG, 32'h0000_0200);
        rd("trig", `ITSQ_OFF_TRIG, 32'h0000_0300);
        rd("exp", `ITSQ_OFF_EXPUS, 32'h0000_2710);
        rd("cmd", `ITSQ_OFF_CMD, 32'h0000_0000);
        rd("unmapped", 8'h40, 32'h0000_0000);
        $display("done reset");
    endtask
    task automatic t_runs();
        wr(`ITSQ_OFF_EXPUS, 32'h2);
        wr(`ITSQ_OFF_RUNCFG, 32'h0000_0102);
        lh <= 1'b1;
        wr(`ITSQ_OFF_CMD, 32'h1);
        wait_done();
        lh <= 1'b0;
        frames("single", 1);
        rd("once clear", `ITSQ_OFF_RUNCFG, 32'h0000_0002);
        rd("auto step", `ITSQ_OFF_EXPUS, 32'h0000_0001);
        chk("rows", 32'h4, 32'(nrow));
        wr(`ITSQ_OFF_TOTAL, 32'h3);
        wr(`ITSQ_OFF_RUNCFG, 32'h1);
        wr(`ITSQ_OFF_CMD, 32'h1);
        wait_done();
        frames("counted", 3);
        $display("done runs");
    endtask
    task automatic t_gated();
        wr(`ITSQ_OFF_RUNCFG, 32'h2);
        wr(`ITSQ_OFF_DLYUS, 32'h3);
        wr(`ITSQ_OFF_TRIG, 32'h0001_0310);
        fire();
        repeat (40) @(posedge clk_i);
        wr(`ITSQ_OFF_CMD, 32'h1);
        wr(`ITSQ_OFF_CMD, 32'h4);
        repeat (40) @(posedge clk_i);
        frames("stray", 0);
        chk("stray expo", 32'h0, {31'h0, expo});
        fire();
        wait_done();
        frames("line rise", 1);
        wr(`ITSQ_OFF_TRIG, 32'h0001_0300);
        wr(`ITSQ_OFF_CMD, 32'h1);
        wr(`ITSQ_OFF_CMD, 32'h4);
        rd("in delay", `ITSQ_OFF_STAT, 32'h0000_0014);
        wait_done();
        frames("soft trig", 1);
        $display("done gated");
    endtask
    task automatic t_cont();
        wr(`ITSQ_OFF_TRIG, 32'h0002_0301);
        // per-frame in single mode: a second trigger needs a new begin
        wr(`ITSQ_OFF_RUNCFG, 32'h2);
        wr(`ITSQ_OFF_CMD, 32'h1);
        wr(`ITSQ_OFF_CMD, 32'h4);
        wait_done();
        wr(`ITSQ_OFF_CMD, 32'h4);
        repeat (100) @(posedge clk_i);
        frames("frame single", 1);
        wr(`ITSQ_OFF_RUNCFG, 32'h0);
        wr(`ITSQ_OFF_CMD, 32'h1);
        repeat (2) begin
            wr(`ITSQ_OFF_CMD, 32'h4);
            repeat (400) @(posedge clk_i);
        end
        frames("per frame", 2);
        chk("still run", 32'h1, {31'h0, run});
        wr(`ITSQ_OFF_CMD, 32'h2);
        wait_done();
        chk("ended", 32'h0, {31'h0, run});
        $display("done cont");
    endtask
    // burst trigger in continuous mode, then with burst-end enabled
    task automatic t_burst();
        wr(`ITSQ_OFF_BURST, 32'h2);
        wr(`ITSQ_OFF_TRIG, 32'h0004_0302);
        wr(`ITSQ_OFF_CMD, 32'h1);
        wr(`ITSQ_OFF_CMD, 32'h4);
        repeat (400) @(posedge clk_i);
        frames("burst", 2);
        wr(`ITSQ_OFF_TRIG, 32'h0014_0302);
        wr(`ITSQ_OFF_CMD, 32'h4);
        repeat (400) @(posedge clk_i);
        frames("burst end", 1);
        chk("burst run", 32'h1, {31'h0, run});
        wr(`ITSQ_OFF_CMD, 32'h2);
        wait_done();
        $display("done burst");
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_reset();
        t_runs();
        t_gated();
        t_cont();
        t_burst();
        end_sim();
    end
endmodule
